// ---- sim/phm_fe_model.sv ----
// Behavioural model of the receiver frontend that streams I/Q samples into the phase unit.
`timescale 1ns/10ps
`include "phm_map.svh"
module phm_fe_model
  import phm_pkg::*;
(
  // Clock and reset.
  input  wire logic      i_mclk,
  input  wire logic      i_rst_n,
  // Vector to be sent in every sample.
  input  wire phm_samp_t i_re,
  input  wire phm_samp_t i_im,
  // Sample stream towards the unit.
  output logic           o_valid,
  output phm_samp_t      o_i,
  output phm_samp_t      o_q
);
  ////////////////////////////////////////////////////////////////////////////////
  int unsigned gap_cnt;

  // one megahertz rate
  // One sample per slot; between samples the data lines flip every cycle so that
  // a design latching them outside a valid cycle shows a wrong result.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gap_cnt <= 0;
      o_valid <= 1'b0;
      o_i     <= '0;
      o_q     <= '0;
    end else if (gap_cnt == `PHM_SLOT_CYC - 1) begin
      gap_cnt <= 0;
      o_valid <= 1'b1;
      o_i     <= i_re;
      o_q     <= i_im;
    end else begin
      gap_cnt <= gap_cnt + 1;
      o_valid <= 1'b0;
      o_i     <= ~o_i;
      o_q     <= ~o_q;
    end
  end
endmodule : phm_fe_model

// ---- sim/testbench.sv ----
// Self-checking bench for the phase measurement unit and its register port.
`timescale 1ns/10ps
`include "phm_map.svh"
module testbench
  import phm_pkg::*;
;
  ////////////////////////////////////////////////////////////////////////////////
  logic           mclk, rst_n, ce, reg_wr, iq_valid, chan_req, chan_apply;
  logic     [2:0] reg_addr;
  logic     [7:0] reg_wdata, reg_rdata;
  phm_samp_t      vec_re, vec_im, iq_i, iq_q;
  int             cyc = 0, w = 0, error_cnt = 0, samples_checked = 0;
  int             apply_cnt = 0, apply_at = 0;
  int             nx[4] = '{800, 566, 0, -800};
  int             ny[4] = '{0, 566, 800, 0};
  int             qx[4] = '{800, 0, -800, 0};
  int             qy[4] = '{0, -800, 0, 800};
  localparam real PI    = 3.14159265358979;
  localparam int  LIMIT = 20000;

  // Free-running 40 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Unit under test and its frontend.
  phm_core uut (.i_mclk(mclk), .i_rst_n(rst_n), .i_ce(ce), .i_reg_wr(reg_wr),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
    .i_iq_valid(iq_valid), .i_iq_i(iq_i), .i_iq_q(iq_q), .i_chan_req(chan_req),
    .o_chan_apply(chan_apply));
  phm_fe_model fe (.i_mclk(mclk), .i_rst_n(rst_n), .i_re(vec_re), .i_im(vec_im),
    .o_valid(iq_valid), .o_i(iq_i), .o_q(iq_q));

  // Cycle count, apply pulse log and hang guard.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (chan_apply === 1'b1) begin
      apply_cnt <= apply_cnt + 1;
      apply_at  <= cyc;
    end
    if (cyc > LIMIT) begin
      error_cnt++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Expected phase code and scaled unit-circle parts, worked out in real arithmetic.
  function automatic logic [7:0] ang(input real x, input real y);
    int p;
    p = int'($atan2(y, x) / PI * 128.0);
    return p[7:0];
  endfunction : ang

  function automatic logic [7:0] nrm(input logic [7:0] c, input bit s);
    real a;
    int  v;
    a = c * PI / 128.0;
    v = s ? int'(63.0 * $sin(a)) : int'(63.0 * $cos(a));
    return v[7:0];
  endfunction : nrm

  // A tolerance is allowed because the angle finder may be one step off.
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got,
                     input int tol);
    logic signed [7:0] d;
    d = got - exp;
    samples_checked++;
    if ($isunknown(got) || d > tol || d < -tol) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    w = cyc;
  endtask : wr

  // Read data follows the address by one edge.
  task automatic rchk(input logic [2:0] a, input string nm, input logic [7:0] exp,
                      input int tol);
    @(posedge mclk);
    reg_addr <= a;
    @(posedge mclk);
    #1 chk(nm, exp, reg_rdata, tol);
  endtask : rchk

  task automatic wait_to(input int n);
    while (cyc < w + n) @(posedge mclk);
  endtask : wait_to

  task automatic setv(input int x, input int y);
    @(posedge mclk);
    vec_re <= phm_samp_t'(x);
    vec_im <= phm_samp_t'(y);
  endtask : setv

  // Several periods pass so that the last one holds only the new vector.
  task automatic check_vec(input int x, input int y, input bit raw);
    logic [7:0] p;
    setv(x, y);
    repeat (1000) @(posedge mclk);
    p = ang(x, y);
    rchk(`PHM_OFS_ANGLE, "phase", p, 1);
    rchk(`PHM_OFS_REAL, "real", raw ? 8'(x / 16) : nrm(p, 0), 1);
    rchk(`PHM_OFS_IMAG, "imag", raw ? 8'(y / 16) : nrm(p, 1), 1);
  endtask : check_vec

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rchk(`PHM_OFS_CTRL, "ctrl reset", `PHM_CTRL_RST, 0);
    for (int a = 1; a < 6; a++) rchk(a[2:0], "result reset", 8'h00, 0);
    wr(`PHM_OFS_ANGLE, 8'hFF);
    rchk(`PHM_OFS_ANGLE, "phase ro", 8'h00, 0);
    wr(`PHM_OFS_CTRL, 8'h1C);
    rchk(`PHM_OFS_CTRL, "slot ro", 8'h00, 0);
  endtask : t_reset

  task automatic t_slots();
    setv(0, 800);
    wr(`PHM_OFS_CTRL, 8'h03);
    for (int k = 0; k < 8; k++) begin
      wait_to(20 + 40 * k);
      rchk(`PHM_OFS_CTRL, "slot", {3'b000, k[2:0], 2'b11}, 0);
    end
    wait_to(300);
    rchk(`PHM_OFS_ANGLE, "before wrap", 8'h00, 0);
    wait_to(330);
    rchk(`PHM_OFS_ANGLE, "first wrap", ang(0, 800), 1);
  endtask : t_slots

  task automatic t_norm();
    for (int k = 0; k < 4; k++) begin
      check_vec(nx[k], ny[k], 1'b0);
      rchk(`PHM_OFS_QUAL, "quality", 8'hFF, 0);
    end
  endtask : t_norm

  task automatic t_fed();
    wr(`PHM_OFS_CTRL, 8'h23);
    repeat (1000) @(posedge mclk);
    rchk(`PHM_OFS_QUAL, "freq offset", 8'h00, 1);
  endtask : t_fed

  // The vector steps at every sample: it turns clockwise a quarter turn per sample,
  // or with alt it swings between two axes, the worst case for phase stability.
  // Clockwise turning gives a negative offset, so a lost sign bit shows up here.
  task automatic t_drift(input logic [7:0] ctl, input bit alt, input string nm,
                         input logic [7:0] exp);
    int k;
    k = 0;
    wr(`PHM_OFS_CTRL, ctl);
    repeat (1000) begin
      @(posedge mclk);
      if (iq_valid) begin
        k = alt ? (k ^ 3) : ((k + 1) % 4);
        vec_re <= phm_samp_t'(qx[k]);
        vec_im <= phm_samp_t'(qy[k]);
      end
    end
    rchk(`PHM_OFS_QUAL, nm, exp, 0);
  endtask : t_drift

  task automatic t_raw();
    wr(`PHM_OFS_CTRL, 8'h43);
    check_vec(-960, 0, 1'b1);
    check_vec(480, -320, 1'b1);
  endtask : t_raw

  // Only the last samples of the period carry the second vector.
  task automatic t_sampled();
    wr(`PHM_OFS_CTRL, 8'h00);
    setv(800, 0);
    wr(`PHM_OFS_CTRL, 8'h01);
    wait_to(250);
    setv(0, -800);
    wait_to(330);
    rchk(`PHM_OFS_ANGLE, "sampled phase", ang(0, -800), 1);
    rchk(`PHM_OFS_IMAG, "sampled imag", nrm(ang(0, -800), 1), 1);
  endtask : t_sampled

  task automatic t_hold();
    wr(`PHM_OFS_CTRL, 8'h00);
    setv(800, 0);
    repeat (700) @(posedge mclk);
    rchk(`PHM_OFS_ANGLE, "held phase", ang(0, -800), 1);
    rchk(`PHM_OFS_CTRL, "idle ctrl", 8'h00, 0);
  endtask : t_hold

  // A low clock enable must stop the slot counter where it stands.
  task automatic t_freeze();
    wr(`PHM_OFS_CTRL, 8'h01);
    wait_to(60);
    ce <= 1'b0;
    repeat (100) @(posedge mclk);
    ce <= 1'b1;
    rchk(`PHM_OFS_CTRL, "frozen slot", 8'h05, 0);
    wr(`PHM_OFS_CTRL, 8'h00);
  endtask : t_freeze

  task automatic t_chan();
    int n0;
    int t;
    n0 = apply_cnt;
    @(posedge mclk);
    chan_req <= 1'b1;
    @(posedge mclk);
    chan_req <= 1'b0;
    t = cyc;
    repeat (4) @(posedge mclk);
    chk("direct count", 8'd1, 8'(apply_cnt - n0), 0);
    chk("direct time", 8'd1, 8'(apply_at - t), 1);
    wr(`PHM_OFS_CTRL, 8'h81);
    n0 = apply_cnt;
    wait_to(100);
    chan_req <= 1'b1;
    @(posedge mclk);
    @(posedge mclk);
    chan_req <= 1'b0;
    wait_to(200);
    chk("early apply", 8'd0, 8'(apply_cnt - n0), 0);
    wait_to(330);
    chk("aligned count", 8'd1, 8'(apply_cnt - n0), 0);
    chk("aligned time", 8'd1, 8'(apply_at - w - 320), 1);
  endtask : t_chan

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset for two cycles, then every scenario in turn.
  initial begin
    rst_n     = 1'b0;
    ce        = 1'b1;
    reg_wr    = 1'b0;
    reg_addr  = 3'h0;
    reg_wdata = 8'h00;
    chan_req  = 1'b0;
    vec_re    = '0;
    vec_im    = '0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_slots();
    t_norm();
    t_fed();
    t_drift(8'h23, 1'b0, "freq drift", 8'h80);
    t_drift(8'h03, 1'b1, "jitter quality", 8'h00);
    t_raw();
    t_sampled();
    t_hold();
    t_freeze();
    t_chan();
    complete_run();
  end
endmodule : testbench

// ---- verilog/phm_angle.sv ----
// Combinational angle finder and unit-circle rotator for the phase unit.
`timescale 1ns/10ps
`include "phm_map.svh"
module phm_angle
  import phm_pkg::*;
(
  // Vector whose argument is wanted.
  input  wire phm_acc_t i_x,
  input  wire phm_acc_t i_y,
  // Angle whose scaled cosine and sine are wanted.
  input  wire phm_ang_t i_ang,
  // Results.
  output phm_ang_t      o_ang,
  output logic [7:0]    o_cos,
  output logic [7:0]    o_sin
);

  logic signed [24:0] vx, vy, tx;
  logic [15:0]        va, ra;
  logic signed [15:0] rx, ry, sx, rc, rs;
  logic               flip;

  // Arctangent of two to the minus k, in turns scaled by 65536.
  function automatic logic [15:0] atan_tab(input int k);
    case (k)
      0:       atan_tab = 16'h2000;
      1:       atan_tab = 16'h12E4;
      2:       atan_tab = 16'h09FB;
      3:       atan_tab = 16'h0511;
      4:       atan_tab = 16'h028B;
      5:       atan_tab = 16'h0146;
      6:       atan_tab = 16'h00A3;
      7:       atan_tab = 16'h0051;
      8:       atan_tab = 16'h0029;
      9:       atan_tab = 16'h0014;
      10:      atan_tab = 16'h000A;
      11:      atan_tab = 16'h0005;
      default: atan_tab = 16'h0000;
    endcase
  endfunction : atan_tab

  ////////////////////////////////////////////////////////////////////////////
  // Vectoring: the left half plane is folded first so twelve steps converge.
  always_comb begin
    vx = {{3{i_x[21]}}, i_x};
    vy = {{3{i_y[21]}}, i_y};
    tx = vx;
    va = 16'h0000;
    if (vx < 0) begin
      vx = -vx;
      vy = -vy;
      va = 16'h8000;
    end
    for (int k = 0; k < 12; k++) begin
      tx = vx;
      if (vy >= 0) begin
        vx = vx + (vy >>> k);
        vy = vy - (tx >>> k);
        va = va + atan_tab(k);
      end else begin
        vx = vx - (vy >>> k);
        vy = vy + (tx >>> k);
        va = va - atan_tab(k);
      end
    end
    // R6: round to 1/256 turn.
    o_ang = 8'((va + 16'h0080) >> 8);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rotation: start vector is 63 divided by the loop gain, 8 fraction bits.
  always_comb begin
    ra   = {i_ang, 8'h00};
    flip = ra[15] ^ ra[14];
    if (flip) begin
      ra = ra ^ 16'h8000;
    end
    rx = `PHM_NORM_X0;
    ry = 16'sh0000;
    sx = rx;
    for (int k = 0; k < 12; k++) begin
      sx = rx;
      if (!ra[15]) begin
        rx = rx - (ry >>> k);
        ry = ry + (sx >>> k);
        ra = ra - atan_tab(k);
      end else begin
        rx = rx + (ry >>> k);
        ry = ry - (sx >>> k);
        ra = ra + atan_tab(k);
      end
    end
    rc = (rx + 16'sh0080) >>> 8;
    rs = (ry + 16'sh0080) >>> 8;
    // R9: the half-turn fold is undone by negation.
    o_cos = flip ? 8'(-rc) : rc[7:0];
    o_sin = flip ? 8'(-rs) : rs[7:0];
  end

endmodule : phm_angle

// ---- verilog/phm_core.sv ----
// Phase measurement unit: period timing, accumulation, results and register port.
// Overview of operation
// R1: Back-to-back 8 us periods, one result set each.
// R2: All results come from the same period.
// R3: Slot counter 0..7 at 1 MHz, control bits 4:2.
// R4: All results load together on 7-to-0 wrap.
// R5: Phase is unsigned, 256 steps per turn.
// R6: Phase is argument over pi times 128, rounded.
// R7: Control bit 1 picks averaging or end sample.
// R8: Average uses all samples; sample uses last.
// R9: Bit 6 clear gives 63 times cos/sin.
// R10: Bit 6 set gives raw rounded real/imag.
// R11: Bit 5 clear gives 0..255 quality, 255 best.
// R12: Quality from inverse mean phase deviation.
// R13: Bit 5 set gives signed frequency offset.
// R14: Software sets frontend rate to 1 MHz first.
// R15: Bit 7 defers channel change to boundary.
// R16: Control bit 0 enables measuring, resets clear.
// R17: Real and imaginary results are signed 8-bit.
// R18: Enable restarts slots; disable keeps results.
`timescale 1ns/10ps
`include "phm_map.svh"
module phm_core
  import phm_pkg::*;
(
  // Clock, reset and clock enable.
  input  wire logic      i_mclk,
  input  wire logic      i_rst_n,
  input  wire logic      i_ce,
  // Register port.
  input  wire logic      i_reg_wr,
  input  wire logic [2:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  output logic [7:0]     o_reg_rdata,
  // Frontend I/Q samples.
  input  wire logic      i_iq_valid,
  input  wire phm_samp_t i_iq_i,
  input  wire phm_samp_t i_iq_q,
  // Channel change request and apply.
  input  wire logic      i_chan_req,
  output logic           o_chan_apply
);

  logic [7:0]        ctrl_r;
  logic [5:0]        presc_r;
  logic [2:0]        slot_r;
  phm_acc_t          sum_i_r, sum_q_r, sum_i_nxt, sum_q_nxt;
  logic [8:0]        cnt_r, cnt_nxt;
  phm_samp_t         last_i_r, last_q_r, last_i_nxt, last_q_nxt;
  phm_ang_t          ph_prev_r;
  logic signed [7:0] pd_prev_r, pd, dd;
  logic [1:0]        have_r;
  logic [16:0]       dev_r, dev_nxt;
  logic signed [16:0] dsum_r, dsum_nxt;
  phm_ang_t          angle_r, qual_r, real_r, imag_r;
  phm_chg_t          chg_r, chg_nxt;
  logic [7:0]        rdata_nxt;
  logic              en, iq_averaging, fed, iq_output_select, align, tick, wrap, hold, apply_nxt;
  phm_acc_t          vec_i, vec_q, mean_i, mean_q, qdiv, qsc, fdiv;
  phm_ang_t          samp_ang, res_ang, norm_c, norm_s, raw_i, raw_q, qf8, fo8;
  phm_ang_t          out_i, out_q, out_qf;

  // Signed mean with a guard for an empty period.
  function automatic phm_acc_t sdiv(input phm_acc_t n, input logic [8:0] d);
    if (d == 9'h000) begin
      sdiv = 22'sh000000;
    end else begin
      sdiv = n / $signed({13'h0000, d});
    end
  endfunction : sdiv

  // Saturate to a signed byte.
  function automatic logic [7:0] sat8(input phm_acc_t v);
    if (v > 22'sd127) begin
      sat8 = 8'h7F;
    end else if (v < -22'sd128) begin
      sat8 = 8'h80;
    end else begin
      sat8 = v[7:0];
    end
  endfunction : sat8

  ////////////////////////////////////////////////////////////////////////////
  // Control fields and period timing events; every event is gated by i_ce.
  assign en    = ctrl_r[`PHM_BIT_EN];
  assign iq_averaging   = ctrl_r[`PHM_BIT_AVG];
  assign fed   = ctrl_r[`PHM_BIT_FED];
  assign iq_output_select = ctrl_r[`PHM_BIT_IQ_OUTPUT_SELECT];
  assign align = ctrl_r[`PHM_BIT_ALIGN];
  assign tick  = i_ce && en && (presc_r == 6'(`PHM_SLOT_CYC - 1));
  // R4: wrap marks the single load instant.
  assign wrap  = tick && (slot_r == `PHM_SLOT_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Accumulators; a sample on the wrap cycle still belongs to the old period.
  // R8: every valid sample enters the sums.
  assign sum_i_nxt  = sum_i_r + (i_iq_valid ? phm_acc_t'(i_iq_i) : 22'sh000000);
  assign sum_q_nxt  = sum_q_r + (i_iq_valid ? phm_acc_t'(i_iq_q) : 22'sh000000);
  assign cnt_nxt    = cnt_r + {8'h00, i_iq_valid};
  assign last_i_nxt = i_iq_valid ? i_iq_i : last_i_r;
  assign last_q_nxt = i_iq_valid ? i_iq_q : last_q_r;

  // R12: phase steps and the change of those steps drive quality.
  assign pd       = $signed(samp_ang - ph_prev_r);
  assign dd       = pd - pd_prev_r;
  assign dev_nxt  = dev_r + ((i_iq_valid && have_r[1]) ?
                    {9'h000, (dd[7] ? 8'(-dd) : dd)} : 17'h00000);
  assign dsum_nxt = dsum_r + ((i_iq_valid && have_r[0]) ?
                    17'(pd) : 17'sh00000);

  ////////////////////////////////////////////////////////////////////////////
  // Period vector: the sum shares the argument of the mean, so no divide here.
  // R7: averaging or end-of-period capture.
  assign vec_i  = iq_averaging ? sum_i_nxt : phm_acc_t'(last_i_nxt);
  assign vec_q  = iq_averaging ? sum_q_nxt : phm_acc_t'(last_q_nxt);
  assign mean_i = iq_averaging ? sdiv(sum_i_nxt, cnt_nxt) : phm_acc_t'(last_i_nxt);
  assign mean_q = iq_averaging ? sdiv(sum_q_nxt, cnt_nxt) : phm_acc_t'(last_q_nxt);
  // R10: raw parts rounded from 12 to 8 bits.
  assign raw_i  = sat8((mean_i + 22'sd8) >>> 4);
  assign raw_q  = sat8((mean_q + 22'sd8) >>> 4);
  // R11: mean deviation scaled, then inverted so 255 is steadiest.
  assign qdiv   = sdiv(phm_acc_t'({5'h00, dev_nxt}), cnt_nxt);
  assign qsc    = phm_acc_t'(qdiv * `PHM_QF_SCALE);
  assign qf8    = (qsc > 22'sd255) ? 8'h00 : 8'(8'hFF - qsc[7:0]);
  // R13: mean step is s/256 turn per sample; twice it gives the code.
  assign fdiv   = sdiv(phm_acc_t'({{4{dsum_nxt[16]}}, dsum_nxt, 1'b0}), cnt_nxt);
  assign fo8    = sat8(fdiv);
  // R17: both parts leave as signed bytes.
  assign out_i  = iq_output_select ? raw_i : norm_c;
  assign out_q  = iq_output_select ? raw_q : norm_s;
  assign out_qf = fed ? fo8 : qf8;

  // Angle of each incoming sample, for the stability and drift figures.
  phm_angle u_samp (
    .i_x   (phm_acc_t'(i_iq_i)),
    .i_y   (phm_acc_t'(i_iq_q)),
    .i_ang (8'h00),
    .o_ang (samp_ang),
    .o_cos (),
    .o_sin ()
  );

  // R5: angle of the period vector, and its normalized components.
  phm_angle u_res (
    .i_x   (vec_i),
    .i_y   (vec_q),
    .i_ang (res_ang),
    .o_ang (res_ang),
    .o_cos (norm_c),
    .o_sin (norm_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Channel change alignment: a request during a hold waits for the boundary.
  assign hold      = align && en && !wrap;
  // R15: defer or apply at once.
  assign apply_nxt = (i_chan_req || chg_r == PHM_CHG_WAIT) && !hold;
  always_comb begin
    case (chg_r)
      PHM_CHG_IDLE: chg_nxt = (i_chan_req && hold) ? PHM_CHG_WAIT : PHM_CHG_IDLE;
      PHM_CHG_WAIT: chg_nxt = hold ? PHM_CHG_WAIT : PHM_CHG_IDLE;
      default:      chg_nxt = PHM_CHG_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped offsets read as zero.
  always_comb begin
    case (i_reg_addr)
      // R3: slot counter shows through bits 4:2.
      `PHM_OFS_CTRL:  rdata_nxt = {ctrl_r[7:5], slot_r, ctrl_r[1:0]};
      `PHM_OFS_ANGLE: rdata_nxt = angle_r;
      `PHM_OFS_QUAL:  rdata_nxt = qual_r;
      `PHM_OFS_REAL:  rdata_nxt = real_r;
      `PHM_OFS_IMAG:  rdata_nxt = imag_r;
      default:        rdata_nxt = 8'h00;
    endcase
  end

  // Control register; the slot bits are read only and never stored.
  // R16: enable bit resets clear.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_r <= `PHM_CTRL_RST;
    end else if (i_ce && i_reg_wr && i_reg_addr == `PHM_OFS_CTRL) begin
      ctrl_r <= i_reg_wdata & `PHM_CTRL_WMSK;
    end
  end

  // R1: prescaler and slot counter.
  // R18: both sit at zero while disabled.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      presc_r <= 6'h00;
      slot_r  <= 3'h0;
    end else if (i_ce) begin
      presc_r <= (!en || tick) ? 6'h00 : presc_r + 6'h01;
      slot_r  <= !en ? 3'h0 : (tick ? slot_r + 3'h1 : slot_r);
    end
  end

  // R8: sums restart each period; the last sample is always kept.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sum_i_r  <= 22'sh000000;
      sum_q_r  <= 22'sh000000;
      cnt_r    <= 9'h000;
      dev_r    <= 17'h00000;
      dsum_r   <= 17'sh00000;
    end else if (i_ce) begin
      sum_i_r  <= (wrap || !en) ? 22'sh000000 : sum_i_nxt;
      sum_q_r  <= (wrap || !en) ? 22'sh000000 : sum_q_nxt;
      cnt_r    <= (wrap || !en) ? 9'h000 : cnt_nxt;
      dev_r    <= (wrap || !en) ? 17'h00000 : dev_nxt;
      dsum_r   <= (wrap || !en) ? 17'sh00000 : dsum_nxt;
    end
  end

  // Phase history runs across periods so the first step of a period counts.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      last_i_r  <= 12'sh000;
      last_q_r  <= 12'sh000;
      ph_prev_r <= 8'h00;
      pd_prev_r <= 8'sh00;
      have_r    <= 2'b00;
    end else if (i_ce) begin
      last_i_r <= last_i_nxt;
      last_q_r <= last_q_nxt;
      if (!en) begin
        have_r <= 2'b00;
      end else if (i_iq_valid) begin
        ph_prev_r <= samp_ang;
        pd_prev_r <= pd;
        have_r    <= {have_r[0], 1'b1};
      end
    end
  end

  // R2: one wrap loads every result from the same period.
  // R4: results hold between wraps and while disabled.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      angle_r <= 8'h00;
      qual_r  <= 8'h00;
      real_r  <= 8'h00;
      imag_r  <= 8'h00;
    end else if (wrap) begin
      angle_r <= res_ang;
      qual_r  <= out_qf;
      real_r  <= out_i;
      imag_r  <= out_q;
    end
  end

  // Registered outputs.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata  <= 8'h00;
      o_chan_apply <= 1'b0;
      chg_r        <= PHM_CHG_IDLE;
    end else if (i_ce) begin
      o_reg_rdata  <= rdata_nxt;
      o_chan_apply <= apply_nxt;
      chg_r        <= chg_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks. The period counter is helper logic read only by the checks.
  logic [9:0] per_cnt;
  logic       per_seen;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      per_cnt  <= 10'h000;
      per_seen <= 1'b0;
    end else if (i_ce) begin
      per_cnt  <= (wrap || !en) ? 10'h000 : per_cnt + 10'h001;
      per_seen <= en && (per_seen || wrap);
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  sequence s_req_held;
    i_chan_req && i_ce && hold;
  endsequence
  sequence s_wait_quiet;
    !o_chan_apply;
  endsequence

  a_period_len: assert property (wrap && per_seen |-> per_cnt == 10'(`PHM_PER_CYC - 1)) // R1
    else $error("period length is not 8 us");
  a_results_same: assert property (wrap |=> angle_r == $past(res_ang)
    && qual_r == $past(out_qf) && real_r == $past(out_i)) // R2
    else $error("results did not load together");
  a_slot_step: assert property (tick && slot_r != 3'h7 |=> slot_r == $past(slot_r) + 3'h1) // R3
    else $error("slot counter did not step");
  a_results_hold: assert property (!wrap |=> $stable(angle_r) && $stable(imag_r)) // R4
    else $error("result changed between wraps");
  a_norm_amp: assert property (wrap && !iq_output_select |=> real_r == $past(norm_c)) // R9
    else $error("normalized real part wrong");
  a_fed_select: assert property (wrap && fed |=> qual_r == $past(fo8)) // R13
    else $error("frequency offset not selected");
  a_align_defer: assert property (s_req_held ##0 (chg_r == PHM_CHG_IDLE) |=> s_wait_quiet) // R15
    else $error("aligned change applied early");
  a_direct_apply: assert property (i_ce && i_chan_req && !align |=> o_chan_apply) // R15
    else $error("direct change not applied");
  a_off_idle: assert property (i_ce && !en |=> slot_r == 3'h0 && $stable(real_r)) // R18
    else $error("disabled unit still running");
  a_sums_clear: assert property (wrap |=> cnt_r == 9'h000 && sum_i_r == 22'sh000000) // R8
    else $error("period sums not restarted");

endmodule : phm_core

// ---- verilog/phm_map.svh ----
// Register offsets, field positions, reset values and timing counts of the phase unit.
`ifndef PHM_MAP_SVH
`define PHM_MAP_SVH

// Register port offsets.
`define PHM_OFS_CTRL  3'h0
`define PHM_OFS_ANGLE 3'h1
`define PHM_OFS_QUAL  3'h2
`define PHM_OFS_REAL  3'h3
`define PHM_OFS_IMAG  3'h4

// Control register fields and reset value.
`define PHM_CTRL_RST  8'h02
`define PHM_BIT_EN    0
`define PHM_BIT_AVG   1
`define PHM_SLOT_LO   2
`define PHM_SLOT_HI   4
`define PHM_BIT_FED   5
`define PHM_BIT_IQ_OUTPUT_SELECT 6
`define PHM_BIT_ALIGN 7
`define PHM_CTRL_WMSK 8'hE3

// Timing: one slot is 1 us, a period holds eight slots.
`define PHM_CLK_NS    25
`define PHM_SLOT_NS   1000
`define PHM_SLOT_CYC  (`PHM_SLOT_NS / `PHM_CLK_NS)
`define PHM_SLOT_LAST 3'h7
`define PHM_PER_CYC   (`PHM_SLOT_CYC * 8)

// Result scaling.
`define PHM_NORM_X0   16'sh2641
`define PHM_QF_SCALE  8

`endif

// ---- verilog/phm_pkg.sv ----
// Types shared by the phase measurement unit modules.
package phm_pkg;
  typedef logic signed [11:0] phm_samp_t;
  typedef logic signed [21:0] phm_acc_t;
  typedef logic [7:0]         phm_ang_t;
  typedef enum logic {
    PHM_CHG_IDLE = 1'b0,
    PHM_CHG_WAIT = 1'b1
  } phm_chg_t;
endpackage : phm_pkg
